// File: testbench/sfh_dev_model.sv
// Flag device model: host side on pins, far side as request levels.
// Assumes host pins change just after the rising clock edge.
`timescale 1ns/1ps
module sfh_dev (
   input wire logic sys_clk,
   input wire sfh_pkg::sfh_pins_t pins,
   input wire logic [7:0] far_req,
   output logic [7:0] host_req = 8'hff,
   output logic [7:0] host_own = 8'h00,
   output logic [15:0] data_in = 16'h0000
);
   logic [7:0] far_own = 8'h00;
   logic rd_q = 1'b0;
   logic rd, h, f;
   assign rd = !pins.flag_space_select_n && !pins.output_en_n && pins.write_n;
   always @(posedge sys_clk) begin
      if (!pins.flag_space_select_n && !pins.write_n)
         host_req[pins.flag_index_lines] <= ~pins.data_out[0];
      for (int i = 0; i < 8; i++) begin
         h = host_own[i] && host_req[i];
         f = far_own[i] && far_req[i];
         if (!h && !f) begin
            h = host_req[i] && !(host_own[i] && far_req[i]);
            f = far_req[i] && !h;
         end
         host_own[i] <= h;
         far_own[i] <= f;
      end
   end
   // Read latch fires half a cycle after select and enable go low
   always @(negedge sys_clk) begin
      rd_q <= rd;
      if (rd && !rd_q) data_in <= {16{~host_own[pins.flag_index_lines]}};
      else if (!rd) data_in <= ~data_in;
   end
endmodule : sfh_dev

// File: testbench/sfh_host_assertions.sv
// Pin sequencing checks for sfh_host.
// Assumes the host drives the flag pins from sys_clk.
`timescale 1ns/1ps
module sfh_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire sfh_pkg::sfh_req_t req,
   input wire logic req_ready,
   input wire logic granted,
   input wire logic init_busy,
   input wire sfh_pkg::sfh_pins_t pins
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic wr, rd, tc, tr;
   assign wr = !pins.flag_space_select_n && !pins.write_n;
   assign rd = !pins.flag_space_select_n && !pins.output_en_n;
   assign tc = req_valid && req_ready && req.cmd == sfh_pkg::SFH_CMD_CLAIM;
   assign tr = req_valid && req_ready && req.cmd == sfh_pkg::SFH_CMD_RELEASE;
   a_write_spread: assert property (wr |-> pins.data_out == {16{pins.data_out[0]}})
      else $error("bits differ");
   a_claim_zero: assert property (tc |-> ##2 wr && !pins.data_out[0])
      else $error("no claim write");
   a_claim_readback: assert property (tc |-> ##5 rd &&
      pins.flag_index_lines == $past(req.index, 5))
      else $error("no read back");
   a_release_one: assert property (tr |-> ##2 wr && pins.data_out[0])
      else $error("no release");
   a_read_short: assert property (rd ##1 rd |=> !rd)
      else $error("read held");
   a_no_rw: assert property (!(wr && !pins.output_en_n))
      else $error("read and write");
   a_init_ones: assert property (init_busy && wr |-> pins.data_out[0])
      else $error("init wrote zero");
   a_grant_read: assert property ($changed(granted) |-> $past(rd) || $past(rd, 2))
      else $error("grant without read");
   cover property (tc);
   cover property ($rose(granted));
   cover property ($fell(init_busy));
endmodule : sfh_chk
bind sfh_host sfh_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .granted(granted), .init_busy(init_busy), .pins(pins));

// File: testbench/tb.sv
// Bench for sfh_host against the flag device model.
// Assumes the far side is driven as request levels per flag.
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   sfh_pkg::sfh_req_t req = '0;
   logic req_ready, done, granted, init_busy, mine;
   sfh_pkg::sfh_pins_t pins;
   logic [15:0] data_in;
   logic [7:0] far_req = 8'h00;
   logic [7:0] host_req, host_own;
   logic [2:0] idx, r;
   int n_mismatch = 0, total_checks = 0, cyc = 0, seed = 96464;
   sfh_host i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .done(done), .granted(granted), .init_busy(init_busy),
      .pins(pins), .data_in(data_in));
   sfh_dev i_dev (.sys_clk(sys_clk), .pins(pins), .far_req(far_req), .host_req(host_req),
      .host_own(host_own), .data_in(data_in));
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(input logic a, input logic e);
      total_checks++;
      if (a !== e) begin
         n_mismatch++;
         $display("Error at %0t: saw %b, expected %b", $time, a, e);
      end
   endtask : chk
   task automatic run(input sfh_pkg::sfh_cmd_t c, input logic [2:0] i);
      int t = 0;
      while (req_ready !== 1'b1 && t < 99) begin
         @(posedge sys_clk); #2; t++;
      end
      req_valid = 1'b1;
      req = '{cmd: c, index: i};
      @(posedge sys_clk); #2;
      req_valid = 1'b0;
      while (done !== 1'b1 && t < 99) begin
         @(posedge sys_clk); #2; t++;
      end
      if (t >= 99) chk(1'b0, 1'b1);
   endtask : run
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20) @(posedge sys_clk);
      #2 rst_n = 1'b1;
      chk(init_busy, 1'b1);
      chk(req_ready, 1'b0);
      run(sfh_pkg::SFH_CMD_POLL, 3'h0);
      chk(host_req == 8'h00, 1'b1);
      $display("Reset test done");
      r = 3'($random(seed));
      for (int k = 0; k < 8; k++) begin
         idx = 3'(k) ^ r;
         far_req = 8'($random(seed));
         @(posedge sys_clk); #2;
         mine = !far_req[idx];
         run(sfh_pkg::SFH_CMD_CLAIM, idx);
         chk(granted, mine);
         if (!mine) begin
            run(sfh_pkg::SFH_CMD_POLL, idx);
            chk(granted, 1'b0);
            far_req[idx] = 1'b0;
            run(sfh_pkg::SFH_CMD_POLL, idx);
            chk(granted, 1'b1);
         end
         far_req[idx] = 1'b1;
         run(sfh_pkg::SFH_CMD_POLL, idx);
         chk(granted, 1'b1);
         run(sfh_pkg::SFH_CMD_RELEASE, idx);
         chk(host_req[idx], 1'b0);
         far_req = 8'h00;
         $display("Flag %0d test done", idx);
      end
      run(sfh_pkg::SFH_CMD_CLAIM, 3'h5);
      run(sfh_pkg::SFH_CMD_INIT, 3'h0);
      chk(host_req == 8'h00, 1'b1);
      chk(init_busy, 1'b0);
      $display("Init test done");
      give_verdict();
   end
endmodule : tb

// File: verilog/sfh_host.sv
// Host controller driving one port of the dual-port semaphore flags.
// Assumes device pins are synchronous to sys_clk; one request at a time.
`timescale 1ns/1ps
module sfh_host (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire sfh_pkg::sfh_req_t req,
   output logic req_ready,
   output logic done,
   output logic granted,
   output logic init_busy,
   output sfh_pkg::sfh_pins_t pins,
   input wire logic [sfh_pkg::DATA_W-1:0] data_in
);
   // ----------------------------------------------------------------
   // Types and storage
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SFH_IDLE,
      SFH_WRITE,
      SFH_GAP,
      SFH_READ,
      SFH_DONE
   } sfh_state_t;

   sfh_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [sfh_pkg::IDX_W-1:0] idx, next_idx;
   logic wr_bit, next_wr_bit;
   logic do_read, next_do_read;
   logic init_mode, next_init_mode;
   logic next_done, next_granted, next_req_ready, next_init_busy;
   sfh_pkg::sfh_pins_t next_pins;
   logic take;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   // Pin word for one phase; deselected strobes idle high
   function automatic sfh_pkg::sfh_pins_t pin_drive(
      input logic sel,
      input logic wr,
      input logic rd,
      input logic [sfh_pkg::IDX_W-1:0] i,
      input logic b
   );
      sfh_pkg::sfh_pins_t p;
      p.flag_space_select_n = ~sel;
      p.write_n = ~wr;
      p.output_en_n = ~rd;
      p.flag_index_lines = i;
      p.data_out = {sfh_pkg::DATA_W{b}};
      p.data_oe = wr;
      return p;
   endfunction : pin_drive

   // Last cycle of a select strobe
   function automatic logic strobe_end(input logic [3:0] c);
      return c == 4'(sfh_pkg::STROBE_CYC - 1);
   endfunction : strobe_end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign take = req_valid && req_ready;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_idx = idx;
      next_wr_bit = wr_bit;
      next_do_read = do_read;
      next_init_mode = init_mode;
      case (state)
         SFH_IDLE: begin
            if (init_mode) begin
               // Free every flag from this side
               next_wr_bit = 1'b1;
               next_do_read = 1'b0;
               next_cnt = sfh_pkg::CNT_RESET;
               next_state = SFH_WRITE;
            end else if (take) begin
               next_idx = req.index;
               next_cnt = sfh_pkg::CNT_RESET;
               case (req.cmd)
                  sfh_pkg::SFH_CMD_CLAIM: begin
                     next_wr_bit = 1'b0;
                     next_do_read = 1'b1;
                     next_state = SFH_WRITE;
                  end
                  sfh_pkg::SFH_CMD_RELEASE: begin
                     next_wr_bit = 1'b1;
                     next_do_read = 1'b0;
                     next_state = SFH_WRITE;
                  end
                  sfh_pkg::SFH_CMD_POLL: begin
                     next_do_read = 1'b1;
                     next_state = SFH_READ;
                  end
                  sfh_pkg::SFH_CMD_INIT: begin
                     next_idx = sfh_pkg::IDX_RESET;
                     next_init_mode = 1'b1;
                  end
                  default: next_state = SFH_IDLE;
               endcase
            end
         end
         SFH_WRITE: begin
            next_cnt = cnt + 4'h1;
            if (strobe_end(cnt)) begin
               next_cnt = sfh_pkg::CNT_RESET;
               next_state = SFH_GAP;
            end
         end
         SFH_GAP: begin
            // Select released so the next read relatches
            next_cnt = cnt + 4'h1;
            if (cnt == 4'(sfh_pkg::GAP_CYC - 1)) begin
               next_cnt = sfh_pkg::CNT_RESET;
               if (do_read) begin
                  next_state = SFH_READ;
               end else if (init_mode && idx != 3'(sfh_pkg::FLAG_COUNT - 1)) begin
                  next_idx = idx + 3'h1;
                  next_state = SFH_WRITE;
               end else begin
                  next_state = SFH_DONE;
               end
            end
         end
         SFH_READ: begin
            next_cnt = cnt + 4'h1;
            if (strobe_end(cnt)) begin
               next_do_read = 1'b0;
               next_cnt = sfh_pkg::CNT_RESET;
               next_state = SFH_GAP;
            end
         end
         SFH_DONE: begin
            next_init_mode = 1'b0;
            next_state = SFH_IDLE;
         end
         default: next_state = SFH_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Host outputs and pins
   // ----------------------------------------------------------------
   always_comb begin
      next_done = 1'b0;
      next_granted = granted;
      next_req_ready = 1'b0;
      next_init_busy = next_init_mode;
      next_pins = pin_drive(1'b0, 1'b0, 1'b0, idx, 1'b1);
      case (state)
         SFH_IDLE: begin
            // Ready drops on the edge that takes a request
            next_req_ready = !init_mode && !take;
         end
         SFH_WRITE: begin
            next_pins = pin_drive(1'b1, 1'b1, 1'b0, idx, wr_bit);
         end
         SFH_READ: begin
            next_pins = pin_drive(1'b1, 1'b0, 1'b1, idx, 1'b1);
            if (strobe_end(cnt)) begin
               // Low on bit zero means this side holds the flag
               next_granted = ~data_in[0];
            end
         end
         SFH_DONE: begin
            next_done = 1'b1;
            next_req_ready = 1'b1;
         end
         default: next_done = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SFH_IDLE;
         cnt <= sfh_pkg::CNT_RESET;
         idx <= sfh_pkg::IDX_RESET;
         wr_bit <= 1'b1;
         do_read <= 1'b0;
         // Latches start unknown, so sweep on leaving reset
         init_mode <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         idx <= next_idx;
         wr_bit <= next_wr_bit;
         do_read <= next_do_read;
         init_mode <= next_init_mode;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
         granted <= 1'b0;
         req_ready <= 1'b0;
         init_busy <= 1'b1;
         pins <= pin_drive(1'b0, 1'b0, 1'b0, sfh_pkg::IDX_RESET, 1'b1);
      end else begin
         done <= next_done;
         granted <= next_granted;
         req_ready <= next_req_ready;
         init_busy <= next_init_busy;
         pins <= next_pins;
      end
   end
endmodule : sfh_host

// File: verilog/sfh_pkg.sv
// Package for the semaphore flag host controller.
// Assumes one 40 MHz clock and a device with an asynchronous SRAM-style port.
package sfh_pkg;
   localparam int FLAG_COUNT = 8;
   localparam int IDX_W = 3;
   localparam int DATA_W = 16;
   // Strobe timing in ns and derived cycles at 40 MHz
   localparam int CLK_PERIOD_NS = 25;
   localparam int STROBE_NS = 50;
   localparam int GAP_NS = 25;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CNT_RESET = 4'h0;
   localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;

   typedef enum logic [1:0] {
      SFH_CMD_CLAIM,
      SFH_CMD_RELEASE,
      SFH_CMD_POLL,
      SFH_CMD_INIT
   } sfh_cmd_t;

   typedef struct packed {
      sfh_cmd_t cmd;
      logic [IDX_W-1:0] index;
   } sfh_req_t;

   typedef struct packed {
      logic flag_space_select_n;
      logic write_n;
      logic output_en_n;
      logic [IDX_W-1:0] flag_index_lines;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
   } sfh_pins_t;
endpackage : sfh_pkg
